/* core/acc_axis_cmp.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_axis_cmp (
  input wire logic [15:0] sample,
  input wire logic [15:0] threshold,
  input wire logic hi_en,
  input wire logic lo_en,
  output logic hi_evt,
  output logic lo_evt
);
  // Samples and threshold are both two's complement.
  assign hi_evt = hi_en & ($signed(sample) > $signed(threshold)); // R10
  assign lo_evt = lo_en & ($signed(sample) < $signed(threshold)); // R11
endmodule
`default_nettype wire

/* core/acc_pkg.sv */
// Summary of operation
// R1 - Power field 00 holds power-down; 01 runs normally.
// R2 - Decimation field selects 128, 64, 32 or 8 modulator ticks per sample.
// R3 - Self-test bit 1 runs self-test; 0 means normal measuring.
// R4 - Each axis has an enable bit; disabled axes are not measured.
// R5 - Full-scale bit 0 selects 2g range, 1 selects 6g range.
// R6 - Pin carries data-ready when route bit 0, wake request when 1; data-ready gated.
// R7 - Serial mode bit 0 selects four-wire SPI, 1 selects three-wire.
// R8 - Alignment bit 0 gives 12-bit right-justified, 1 gives 16-bit left-justified.
// R9 - With latch bit set, a wake request stays asserted once raised.
// R10 - Enabled high event raises wake request when axis sample exceeds threshold.
// R11 - Enabled low event raises wake request when axis sample falls below threshold.
// R12 - Source register holds active and per-axis flags; acknowledge read clears it.
// R13 - Status holds per-axis overrun flags and a combined overrun flag.
// R14 - Status holds per-axis new-sample flags and an all-axes new-sample flag.
// R15 - In 12-bit mode, high byte bits 7:4 copy bit 3 for sign extension.
// R16 - Each sample splits into low then high byte at consecutive addresses.
// R17 - Wake threshold is 16 bits from a low and a high byte register.
// R18 - Each axis has an 8-bit read/write gain trim register.
// R19 - Each axis has an 8-bit read/write offset trim register.
// R20 - Reboot bit reloads trims from non-volatile storage, then clears itself.
// R21 - Overwriting an unread sample sets overrun; reading output clears flags.
// R22 - Without latch, wake request drops once no enabled condition is true.
package acc_pkg;
  localparam logic [6:0] ADDR_OFS_X = 7'h16;
  localparam logic [6:0] ADDR_OFS_Y = 7'h17;
  localparam logic [6:0] ADDR_OFS_Z = 7'h18;
  localparam logic [6:0] ADDR_GAIN_X = 7'h19;
  localparam logic [6:0] ADDR_GAIN_Y = 7'h1a;
  localparam logic [6:0] ADDR_GAIN_Z = 7'h1b;
  localparam logic [6:0] ADDR_MEAS_CTRL = 7'h20;
  localparam logic [6:0] ADDR_IF_CTRL = 7'h21;
  localparam logic [6:0] ADDR_WAKE_CFG = 7'h23;
  localparam logic [6:0] ADDR_WAKE_SRC = 7'h24;
  localparam logic [6:0] ADDR_WAKE_ACK = 7'h25;
  localparam logic [6:0] ADDR_STATUS = 7'h27;
  localparam logic [6:0] ADDR_X_LOW = 7'h28;
  localparam logic [6:0] ADDR_X_HIGH = 7'h29;
  localparam logic [6:0] ADDR_Y_LOW = 7'h2a;
  localparam logic [6:0] ADDR_Y_HIGH = 7'h2b;
  localparam logic [6:0] ADDR_Z_LOW = 7'h2c;
  localparam logic [6:0] ADDR_Z_HIGH = 7'h2d;
  localparam logic [6:0] ADDR_THS_LOW = 7'h2e;
  localparam logic [6:0] ADDR_THS_HIGH = 7'h2f;
  // Measure control fields.
  localparam int MC_PWR_LSB = 6;
  localparam int MC_DEC_LSB = 4;
  localparam int MC_SELF_TEST = 3;
  localparam logic [1:0] PWR_DOWN = 2'h0;
  localparam logic [1:0] PWR_ON = 2'h1;
  // Interface control fields; bits 6:5 are reserved and read zero.
  localparam int IC_FULL_SCALE = 7;
  localparam int IC_REBOOT = 4;
  localparam int IC_PIN_ROUTE = 3;
  localparam int IC_DATA_READY_GEN_ENABLE_EN = 2;
  localparam int IC_SERIAL_MODE = 1;
  localparam int IC_JUSTIFY = 0;
  localparam logic [7:0] IC_WR_MASK = 8'h9f;
  // Wake configuration and source fields.
  localparam int WC_LATCH = 6;
  localparam int WS_ACTIVE = 6;
  // Status fields.
  localparam int ST_ALL_OVR = 7;
  localparam int ST_OVR_LSB = 4;
  localparam int ST_ALL_NEW = 3;
  localparam int ST_NEW_LSB = 0;
  // Decimation ratios, as tick count minus one.
  localparam logic [6:0] DEC_LIM_128 = 7'h7f;
  localparam logic [6:0] DEC_LIM_64 = 7'h3f;
  localparam logic [6:0] DEC_LIM_32 = 7'h1f;
  localparam logic [6:0] DEC_LIM_8 = 7'h07;
  // Reset values.
  localparam logic [7:0] MEAS_CTRL_RST = 8'h07;
  localparam logic [7:0] IF_CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_CFG_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [7:0] THS_RST = 8'h00;
  // Six trim words, offsets first, are reloaded on reboot.
  localparam logic [2:0] TRIM_WORDS = 3'h6;
  typedef enum logic [1:0] {
    ACC_BOOT_IDLE = 2'b00,
    ACC_BOOT_ADDR = 2'b01,
    ACC_BOOT_DATA = 2'b10
  } acc_boot_t;
endpackage

/* core/acc_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_regs import acc_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic adc_tick,
  input wire logic [15:0] adc_x,
  input wire logic [15:0] adc_y,
  input wire logic [15:0] adc_z,
  output logic [2:0] nvm_addr,
  input wire logic [7:0] nvm_rdata,
  output logic rdy_int,
  output logic power_on,
  output logic self_test_drive,
  output logic [2:0] axis_on,
  output logic full_scale_out,
  output logic spi_three_wire,
  output logic [47:0] trim_out
);
  logic [7:0] trim_reg [6];
  logic [7:0] meas_ctrl_reg;
  logic [7:0] if_ctrl_reg;
  logic [7:0] wake_cfg_reg;
  logic [7:0] wake_src_reg;
  logic [7:0] wake_src_next;
  logic [7:0] status_reg;
  logic [15:0] ths_reg;
  logic [15:0] samp_reg [3];
  logic [6:0] dec_cnt_reg;
  logic [6:0] dec_lim;
  logic [2:0] boot_idx_reg;
  acc_boot_t boot_state_reg;
  logic [2:0] hi_evt;
  logic [2:0] lo_evt;
  logic [5:0] live_evt;
  logic [2:0] new_set;
  logic [2:0] new_clr;
  logic [2:0] ovr_next;
  logic [2:0] new_next;
  logic run;
  logic upd;
  logic ack_rd;
  logic [7:0] rd_mux;

  assign run = (meas_ctrl_reg[MC_PWR_LSB +: 2] == PWR_ON); // R1

  always_comb begin
    case (meas_ctrl_reg[MC_DEC_LSB +: 2]) // R2
      2'h0: dec_lim = DEC_LIM_128;
      2'h1: dec_lim = DEC_LIM_64;
      2'h2: dec_lim = DEC_LIM_32;
      default: dec_lim = DEC_LIM_8;
    endcase
  end

  // A sample set is taken when the decimation count has seen enough ticks.
  assign upd = run & adc_tick & (dec_cnt_reg == dec_lim);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dec_cnt_reg <= 7'h00;
    end else if (!run) begin
      dec_cnt_reg <= 7'h00; // R1
    end else if (adc_tick) begin
      dec_cnt_reg <= (dec_cnt_reg >= dec_lim) ? 7'h00 : dec_cnt_reg + 7'h01; // R2
    end
  end

  // Front-end words arrive left justified; only enabled axes are refreshed.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        samp_reg[i] <= 16'h0000;
      end
    end else if (upd) begin
      if (meas_ctrl_reg[0]) begin
        samp_reg[0] <= adc_x; // R4
      end
      if (meas_ctrl_reg[1]) begin
        samp_reg[1] <= adc_y; // R4
      end
      if (meas_ctrl_reg[2]) begin
        samp_reg[2] <= adc_z; // R4
      end
    end
  end

  assign ack_rd = reg_rd & (reg_addr == ADDR_WAKE_ACK);
  assign new_set = upd ? meas_ctrl_reg[2:0] : 3'h0;
  assign new_clr[0] = reg_rd & (reg_addr == ADDR_X_HIGH); // R21
  assign new_clr[1] = reg_rd & (reg_addr == ADDR_Y_HIGH); // R21
  assign new_clr[2] = reg_rd & (reg_addr == ADDR_Z_HIGH); // R21

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // A new sample in the same cycle as the clearing read wins.
      new_next[i] = new_set[i] | (status_reg[ST_NEW_LSB + i] & ~new_clr[i]); // R14
      ovr_next[i] = (new_set[i] & status_reg[ST_NEW_LSB + i])
                    | (status_reg[ST_OVR_LSB + i] & ~new_clr[i]); // R21
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_reg <= 8'h00;
    end else begin
      status_reg[ST_NEW_LSB +: 3] <= new_next; // R14
      status_reg[ST_ALL_NEW] <= &new_next; // R14
      status_reg[ST_OVR_LSB +: 3] <= ovr_next; // R13
      status_reg[ST_ALL_OVR] <= |ovr_next; // R13
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_cmp
    acc_axis_cmp u_cmp (
      .sample(samp_reg[g]),
      .threshold(ths_reg), // R17
      .hi_en(wake_cfg_reg[2 * g + 1]),
      .lo_en(wake_cfg_reg[2 * g]),
      .hi_evt(hi_evt[g]),
      .lo_evt(lo_evt[g])
    );
  end

  assign live_evt = {hi_evt[2], lo_evt[2], hi_evt[1], lo_evt[1], hi_evt[0], lo_evt[0]};

  always_comb begin
    wake_src_next = 8'h00;
    if (wake_cfg_reg[WC_LATCH]) begin
      // A live event arriving during the acknowledge read is kept.
      wake_src_next[5:0] = live_evt | (ack_rd ? 6'h00 : wake_src_reg[5:0]); // R9
    end else begin
      wake_src_next[5:0] = live_evt; // R22
    end
    wake_src_next[WS_ACTIVE] = |wake_src_next[5:0]; // R12
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wake_src_reg <= 8'h00;
    end else begin
      wake_src_reg <= wake_src_next; // R12
    end
  end

  // Control and threshold writes; in the trim block below, the ACC_BOOT_DATA cycles of a reboot win over trim writes.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meas_ctrl_reg <= MEAS_CTRL_RST;
      wake_cfg_reg <= WAKE_CFG_RST;
      ths_reg <= {THS_RST, THS_RST};
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_MEAS_CTRL: meas_ctrl_reg <= reg_wdata;
        ADDR_WAKE_CFG: wake_cfg_reg <= reg_wdata & 8'h7f;
        ADDR_THS_LOW: ths_reg[7:0] <= reg_wdata; // R17
        ADDR_THS_HIGH: ths_reg[15:8] <= reg_wdata; // R17
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      if_ctrl_reg <= IF_CTRL_RST;
    end else if (reg_wr && reg_addr == ADDR_IF_CTRL) begin
      if_ctrl_reg <= reg_wdata & IC_WR_MASK;
    end else if (boot_state_reg == ACC_BOOT_DATA && boot_idx_reg == TRIM_WORDS - 3'h1) begin
      if_ctrl_reg[IC_REBOOT] <= 1'b0; // R20
    end
  end

  // Reload walks the six stored words; storage answers in the same cycle the address is driven.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      boot_state_reg <= ACC_BOOT_IDLE;
      boot_idx_reg <= 3'h0;
    end else begin
      case (boot_state_reg)
        ACC_BOOT_IDLE: begin
          boot_idx_reg <= 3'h0;
          if (if_ctrl_reg[IC_REBOOT]) begin
            boot_state_reg <= ACC_BOOT_ADDR; // R20
          end
        end
        ACC_BOOT_ADDR: boot_state_reg <= ACC_BOOT_DATA;
        ACC_BOOT_DATA: begin
          if (boot_idx_reg == TRIM_WORDS - 3'h1) begin
            boot_state_reg <= ACC_BOOT_IDLE;
          end else begin
            boot_idx_reg <= boot_idx_reg + 3'h1;
            boot_state_reg <= ACC_BOOT_ADDR;
          end
        end
        default: boot_state_reg <= ACC_BOOT_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < 6; i++) begin
        trim_reg[i] <= TRIM_RST;
      end
    end else if (boot_state_reg == ACC_BOOT_DATA) begin
      trim_reg[boot_idx_reg] <= nvm_rdata; // R20
    end else if (reg_wr && reg_addr >= ADDR_OFS_X && reg_addr <= ADDR_GAIN_Z) begin
      trim_reg[3'(reg_addr - ADDR_OFS_X)] <= reg_wdata; // R18 R19
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      ADDR_OFS_X, ADDR_OFS_Y, ADDR_OFS_Z,
      ADDR_GAIN_X, ADDR_GAIN_Y, ADDR_GAIN_Z: rd_mux = trim_reg[3'(reg_addr - ADDR_OFS_X)]; // R18 R19
      ADDR_MEAS_CTRL: rd_mux = meas_ctrl_reg;
      ADDR_IF_CTRL: rd_mux = if_ctrl_reg;
      ADDR_WAKE_CFG: rd_mux = wake_cfg_reg;
      ADDR_WAKE_SRC, ADDR_WAKE_ACK: rd_mux = wake_src_reg; // R12
      ADDR_STATUS: rd_mux = status_reg;
      ADDR_THS_LOW: rd_mux = ths_reg[7:0];
      ADDR_THS_HIGH: rd_mux = ths_reg[15:8];
      ADDR_X_LOW, ADDR_Y_LOW, ADDR_Z_LOW,
      ADDR_X_HIGH, ADDR_Y_HIGH, ADDR_Z_HIGH: begin
        // Low byte sits at the even address, high byte right above it.
        if (if_ctrl_reg[IC_JUSTIFY]) begin
          rd_mux = reg_addr[0] ? samp_reg[2'(reg_addr[2:1] - 2'h0)][15:8]
                               : samp_reg[2'(reg_addr[2:1] - 2'h0)][7:0]; // R16 R8
        end else if (reg_addr[0]) begin
          rd_mux = {{4{samp_reg[2'(reg_addr[2:1])][15]}},
                    samp_reg[2'(reg_addr[2:1])][15:12]}; // R15
        end else begin
          rd_mux = samp_reg[2'(reg_addr[2:1])][11:4]; // R8
        end
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdy_int <= 1'b0;
    end else if (if_ctrl_reg[IC_PIN_ROUTE]) begin
      rdy_int <= wake_src_reg[WS_ACTIVE]; // R6
    end else begin
      rdy_int <= if_ctrl_reg[IC_DATA_READY_GEN_ENABLE_EN] & status_reg[ST_ALL_NEW]; // R6
    end
  end

  // Front-end controls are registered so the analog side never sees decode glitches.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      power_on <= 1'b0;
      self_test_drive <= 1'b0;
      axis_on <= 3'h0;
      full_scale_out <= 1'b0;
      spi_three_wire <= 1'b0;
      nvm_addr <= 3'h0;
      trim_out <= 48'h0000_0000_0000;
    end else begin
      power_on <= run; // R1
      self_test_drive <= run & meas_ctrl_reg[MC_SELF_TEST]; // R3
      axis_on <= run ? meas_ctrl_reg[2:0] : 3'h0; // R4
      full_scale_out <= if_ctrl_reg[IC_FULL_SCALE]; // R5
      spi_three_wire <= if_ctrl_reg[IC_SERIAL_MODE]; // R7
      nvm_addr <= boot_idx_reg; // R20
      trim_out <= {trim_reg[5], trim_reg[4], trim_reg[3],
                   trim_reg[2], trim_reg[1], trim_reg[0]}; // R18 R19
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  power_hold_a: assert property (!run |=> $stable(samp_reg[0])) // R1
    else $error("sample changed while powered down");
  dec_count_a: assert property (upd |-> dec_cnt_reg == dec_lim ##1 dec_cnt_reg == 7'h00) // R2
    else $error("decimation count not restarted");
  self_test_a: assert property (##1 self_test_drive == $past(run & meas_ctrl_reg[MC_SELF_TEST])) // R3
    else $error("self-test drive wrong");
  axis_off_a: assert property (upd && !meas_ctrl_reg[0] |=> $stable(samp_reg[0])) // R4
    else $error("disabled axis updated");
  pin_route_a: assert property (if_ctrl_reg[IC_PIN_ROUTE] && $stable(if_ctrl_reg)
    |=> rdy_int == $past(wake_src_reg[WS_ACTIVE])) // R6
    else $error("wake request not routed to pin");
  wake_latch_a: assert property (wake_cfg_reg[WC_LATCH] && wake_src_reg[0] && !ack_rd
    && !(reg_wr && reg_addr == ADDR_WAKE_CFG) |=> wake_src_reg[0]) // R9
    else $error("latched wake flag lost");
  wake_live_a: assert property (!wake_cfg_reg[WC_LATCH] |=> wake_src_reg[5:0] == $past(live_evt)) // R22
    else $error("unlatched source not following compare");
  ack_clear_a: assert property (ack_rd && live_evt == 6'h00 |=> wake_src_reg == 8'h00) // R12
    else $error("acknowledge read did not clear source");
  overrun_set_a: assert property (upd && meas_ctrl_reg[0] && status_reg[0]
    |=> status_reg[ST_OVR_LSB] && status_reg[ST_ALL_OVR]) // R21
    else $error("overrun not flagged");
  sign_ext_a: assert property (reg_rd && reg_addr == ADDR_X_HIGH && !if_ctrl_reg[IC_JUSTIFY]
    |=> reg_rdata[7:4] == {4{reg_rdata[3]}}) // R15
    else $error("high byte not sign extended");
  reboot_done_a: assert property ($rose(if_ctrl_reg[IC_REBOOT]) |-> ##[12:14] !if_ctrl_reg[IC_REBOOT]) // R20
    else $error("reboot bit did not clear");
endmodule
`default_nettype wire

/* dv/acc_nvm_model.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_nvm_model #(
  parameter logic [47:0] WORDS = 48'h6655_4433_2211
) (
  input wire logic mclk,
  input wire logic [2:0] nvm_addr,
  output logic [7:0] nvm_rdata
);
  // The reload samples the word of the address it drove one cycle earlier.
  // So the storage must answer within the cycle, not one edge later.
  // Words past the table read a fixed filler, so a stray fetch never passes for real data.
  always_comb begin
    if (nvm_addr < 3'h6) begin
      nvm_rdata = WORDS[8*nvm_addr +: 8];
    end else begin
      nvm_rdata = 8'h5a;
    end
  end
endmodule
`default_nettype wire

/* dv/accel_control_and_wakeup_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module accel_control_and_wakeup_regs_bench import acc_pkg::*;;
  localparam logic [47:0] NVM_WORDS = 48'hc3b2_a190_8f7e;
  logic mclk, sys_rst, reg_wr, reg_rd, adc_tick, rdy_int, power_on, self_test_drive;
  logic full_scale_out, spi_three_wire;
  logic rd_seen = 1'h0;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, nvm_rdata, tmp;
  logic [15:0] adc_x, adc_y, adc_z;
  logic [2:0] nvm_addr, axis_on;
  logic [47:0] trim_out;
  logic [7:0] exp_q[$];
  logic [15:0] s [3];
  logic [6:0] rw_addr [8] = '{ADDR_OFS_X, ADDR_OFS_Y, ADDR_OFS_Z, ADDR_GAIN_X,
    ADDR_GAIN_Y, ADDR_GAIN_Z, ADDR_THS_LOW, ADDR_THS_HIGH};
  int lim [4] = '{128, 64, 32, 8};
  int fails = 0;
  int check_count = 0;

  acc_regs uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_tick(adc_tick),
    .adc_x(adc_x), .adc_y(adc_y), .adc_z(adc_z), .nvm_addr(nvm_addr),
    .nvm_rdata(nvm_rdata), .rdy_int(rdy_int), .power_on(power_on),
    .self_test_drive(self_test_drive), .axis_on(axis_on), .full_scale_out(full_scale_out),
    .spi_three_wire(spi_three_wire), .trim_out(trim_out));
  acc_nvm_model #(.WORDS(NVM_WORDS)) nvm (.mclk(mclk), .nvm_addr(nvm_addr),
    .nvm_rdata(nvm_rdata));

  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Pin outputs packed into one byte: rdy, power, self-test, scale, wire, axes.
  function automatic logic [7:0] pins();
    return {rdy_int, power_on, self_test_drive, full_scale_out, spi_three_wire, axis_on};
  endfunction

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'h0;
  endtask

  // Read data is registered, so it is judged half a cycle after the taking edge.
  always @(posedge mclk) rd_seen <= reg_rd;
  always @(negedge mclk) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(reg_rdata, exp_q.pop_front());
    end
  end

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      adc_tick <= 1'h1;
      @(posedge mclk);
      adc_tick <= 1'h0;
    end
    repeat (3) @(posedge mclk);
  endtask

  task automatic set_adc(input logic rnd);
    if (rnd) begin
      for (int i = 0; i < 3; i++) s[i] = 16'($urandom);
    end
    @(posedge mclk);
    adc_x <= s[0];
    adc_y <= s[1];
    adc_z <= s[2];
  endtask

  task automatic load(input logic rnd);
    set_adc(rnd);
    ticks(8);
  endtask

  function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi, input logic j);
    if (j) return hi ? v[15:8] : v[7:0];
    return hi ? {{4{v[15]}}, v[15:12]} : v[11:4];
  endfunction

  task automatic rd_axes(input logic j);
    for (int i = 0; i < 3; i++) begin
      rd(ADDR_X_LOW + 7'(2*i), byte_of(s[i], 1'h0, j));
      rd(ADDR_X_HIGH + 7'(2*i), byte_of(s[i], 1'h1, j));
    end
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    sys_rst = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    adc_tick = 1'h0;
    adc_x = 16'h0000;
    adc_y = 16'h0000;
    adc_z = 16'h0000;
    void'($urandom(32'h5af6_90f9));
    repeat (20) @(posedge mclk);
    chk(pins(), 8'h00);
    sys_rst <= 1'h0;
    rd(ADDR_MEAS_CTRL, MEAS_CTRL_RST);
    rd(ADDR_IF_CTRL, 8'h00);
    rd(7'h30, 8'h00);
    for (int i = 0; i < 8; i++) begin
      tmp = 8'($urandom);
      wr(rw_addr[i], tmp);
      rd(rw_addr[i], tmp);
    end
    wr(ADDR_STATUS, 8'hff);
    wr(ADDR_X_HIGH, 8'hff);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_X_HIGH, 8'h00);
    wr(ADDR_MEAS_CTRL, 8'h4a);
    repeat (3) @(posedge mclk);
    chk(pins(), 8'h62);
    wr(ADDR_IF_CTRL, 8'he3);
    rd(ADDR_IF_CTRL, 8'h83);
    chk(pins(), 8'h7a);
    wr(ADDR_MEAS_CTRL, 8'h77);
    repeat (3) @(posedge mclk);
    chk(pins(), 8'h5f);
    wr(ADDR_MEAS_CTRL, 8'h37);
    repeat (3) @(posedge mclk);
    chk(pins(), 8'h18);
    ticks(130);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_IF_CTRL, 8'h04);
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_MEAS_CTRL, 8'h07);
      wr(ADDR_MEAS_CTRL, 8'h47 | 8'(d << 4));
      set_adc(1'h1);
      ticks(lim[d] - 1);
      rd(ADDR_STATUS, 8'h00);
      ticks(1);
      rd(ADDR_STATUS, 8'h0f);
      chk(pins(), 8'hc7);
      rd_axes(1'h0);
      chk(pins(), 8'h47);
    end
    load(1'h1);
    load(1'h1);
    rd(ADDR_STATUS, 8'hff);
    rd_axes(1'h0);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_IF_CTRL, 8'h05);
    load(1'h1);
    rd_axes(1'h1);
    wr(ADDR_THS_LOW, 8'h00);
    wr(ADDR_THS_HIGH, 8'h10);
    wr(ADDR_IF_CTRL, 8'h08);
    wr(ADDR_WAKE_CFG, 8'h52);
    s = '{16'h4000, 16'h0000, 16'h0000};
    load(1'h0);
    rd(ADDR_WAKE_SRC, 8'h52);
    chk(pins(), 8'hc7);
    s = '{16'h0000, 16'h0000, 16'h2000};
    load(1'h0);
    rd(ADDR_WAKE_SRC, 8'h52);
    rd(ADDR_WAKE_ACK, 8'h52);
    rd(ADDR_WAKE_SRC, 8'h00);
    repeat (3) @(posedge mclk);
    chk(pins(), 8'h47);
    wr(ADDR_WAKE_CFG, 8'h02);
    s = '{16'h4000, 16'h0000, 16'h0000};
    load(1'h0);
    rd(ADDR_WAKE_SRC, 8'h42);
    s = '{16'hc000, 16'h0000, 16'h0000};
    load(1'h0);
    rd(ADDR_WAKE_SRC, 8'h00);
    chk(pins(), 8'h47);
    wr(ADDR_WAKE_CFG, 8'h01);
    load(1'h0);
    rd(ADDR_WAKE_SRC, 8'h41);
    wr(ADDR_IF_CTRL, 8'h10);
    repeat (20) @(posedge mclk);
    rd(ADDR_IF_CTRL, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rd(rw_addr[i], NVM_WORDS[8*i +: 8]);
      chk(trim_out[8*i +: 8], NVM_WORDS[8*i +: 8]);
    end
    repeat (4) @(posedge mclk);
    close_out();
  end

  // The full sequence needs about 1200 cycles; this margin only catches a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
